/* stc_timer_core.sv */
// Design decisions made here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/100ps
// Function
// - 16-bit counter steps on each timer clock
// - software reads and loads counter immediately
// - clear zeroes counter, dividers and direction
// - four selectable timer clock sources
// - first divider passes or divides by 2/4/8
// - second divider divides by one to eight
// - down counter dividers tick on first edge
// - count only when mode nonzero, source active
// - zero period stops up and up/down modes; nonzero restarts from zero
// - mode field: stop, up, continuous, up/down
// - up mode runs zero to period, wraps
// - up mode above period restarts at zero
// - continuous mode wraps at full scale
// - up/down runs to period and back
// - compare flag set counting up to period
// - overflow flag set counting period to zero
// - software loaded values trigger no flags
// - overflow and compare raise interrupt requests
module stc_timer_core (
  // system
  input  wire logic                      SYS_CLK,
  input  wire logic                      SRST,
  // timer clock source pins
  input  wire logic                      AUX_CLOCK,
  input  wire logic                      SUB_MAIN_CLOCK,
  input  wire logic                      EXTERNAL_TIMER_CLOCK,
  input  wire logic                      ALTERNATE_EXTERNAL_CLOCK,
  // axi4-lite write address
  input  wire logic [stc_pkg::ADDR_W-1:0] S_AXI_AWADDR,
  input  wire logic                      S_AXI_AWVALID,
  output      logic                      S_AXI_AWREADY,
  // axi4-lite write data
  input  wire logic [31:0]               S_AXI_WDATA,
  input  wire logic [3:0]                S_AXI_WSTRB,
  input  wire logic                      S_AXI_WVALID,
  output      logic                      S_AXI_WREADY,
  // axi4-lite write response
  output      logic [1:0]                S_AXI_BRESP,
  output      logic                      S_AXI_BVALID,
  input  wire logic                      S_AXI_BREADY,
  // axi4-lite read address
  input  wire logic [stc_pkg::ADDR_W-1:0] S_AXI_ARADDR,
  input  wire logic                      S_AXI_ARVALID,
  output      logic                      S_AXI_ARREADY,
  // axi4-lite read data
  output      logic [31:0]               S_AXI_RDATA,
  output      logic [1:0]                S_AXI_RRESP,
  output      logic                      S_AXI_RVALID,
  input  wire logic                      S_AXI_RREADY,
  // interrupt requests
  output      logic                      TIMER_OVF_IRQ,
  output      logic                      TIMER_CMP_IRQ
);
  import stc_pkg::*;

  // ****************************************************************
  // clock source synchronisers
  // ****************************************************************
  logic [3:0] src_pin;    // raw source pins
  logic [3:0] src_meta;   // first stage, read by second stage only
  logic [3:0] src_sync;   // second stage
  logic [3:0] src_prev;   // delayed copy for edge detect
  logic [3:0] src_rise;   // one pulse per source rising edge

  assign src_pin = {ALTERNATE_EXTERNAL_CLOCK, EXTERNAL_TIMER_CLOCK,
                    SUB_MAIN_CLOCK, AUX_CLOCK};

  // one synchroniser chain per source pin
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
          src_meta[gi] <= 1'b0;
          src_sync[gi] <= 1'b0;
          src_prev[gi] <= 1'b0;
        end else begin
          src_meta[gi] <= src_pin[gi];
          src_sync[gi] <= src_meta[gi];
          src_prev[gi] <= src_sync[gi];
        end
      end
      assign src_rise[gi] = src_sync[gi] & ~src_prev[gi];
    end
  endgenerate

  // ****************************************************************
  // register state
  // ****************************************************************
  stc_cfg_t    cfg;          // mode, source and divider setup
  logic [15:0] count;        // count_value
  logic [15:0] period;       // period_compare_reg
  logic        dir_down;     // latched up/down direction
  logic        ovf_flag;     // overflow_flag
  logic        cmp_flag;     // compare_flag, channel zero
  logic [2:0]  div1_cnt;     // first divider down counter
  logic [2:0]  div2_cnt;     // second divider down counter

  // ****************************************************************
  // axi4-lite slave
  // ****************************************************************
  logic [7:0]  aw_addr;      // held write address
  logic        aw_held;      // write address captured
  logic [31:0] w_data;       // held write data
  logic [3:0]  w_strb;       // held byte enables
  logic        w_held;       // write data captured
  logic        wr_fire;      // both halves present, commit now
  logic        wr_hit;       // committed address is mapped
  logic [15:0] wr_merge;     // low half merged through strobes
  logic [15:0] wr_old;       // current value of written register
  logic        ar_fire;      // read address accepted
  logic [31:0] rd_word;      // read mux output
  logic        rd_hit;       // read address is mapped

  // ready only while nothing is parked, so one write at a time
  assign S_AXI_AWREADY = ~aw_held & ~S_AXI_BVALID;
  assign S_AXI_WREADY  = ~w_held & ~S_AXI_BVALID;
  assign S_AXI_ARREADY = ~S_AXI_RVALID;
  assign wr_fire       = aw_held & w_held & ~S_AXI_BVALID;
  assign ar_fire       = S_AXI_ARVALID & S_AXI_ARREADY;

  // address decode of the committed write
  logic wr_ctrl, wr_count, wr_period, wr_divx, wr_flags;
  assign wr_ctrl   = wr_fire && aw_addr == ADDR_CTRL;
  assign wr_count  = wr_fire && aw_addr == ADDR_COUNT;
  assign wr_period = wr_fire && aw_addr == ADDR_PERIOD;
  assign wr_divx   = wr_fire && aw_addr == ADDR_DIVX;
  assign wr_flags  = wr_fire && aw_addr == ADDR_FLAGS;
  assign wr_hit    = wr_ctrl | wr_count | wr_period | wr_divx | wr_flags;

  // byte lanes above bit 15 hold nothing, so only two lanes matter
  assign wr_old   = (aw_addr == ADDR_COUNT) ? count : period;
  assign wr_merge = {w_strb[1] ? w_data[15:8] : wr_old[15:8],
                     w_strb[0] ? w_data[7:0]  : wr_old[7:0]};

  // capture address and data in either order
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_held <= 1'b1;
        aw_addr <= S_AXI_AWADDR;
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_held <= 1'b1;
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
    end
  end

  // write response, slverr for unmapped offsets
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= RESP_OKAY;
    end else if (wr_fire) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // read mux; clear bit always reads back zero
  assign rd_hit  = S_AXI_ARADDR == ADDR_CTRL  ||
                   S_AXI_ARADDR == ADDR_COUNT ||
                   S_AXI_ARADDR == ADDR_PERIOD ||
                   S_AXI_ARADDR == ADDR_DIVX  ||
                   S_AXI_ARADDR == ADDR_FLAGS;
  assign rd_word =
    (S_AXI_ARADDR == ADDR_CTRL)   ? {22'h0, cfg.src, cfg.div1,
                                     cfg.mode, 4'h0} :
    (S_AXI_ARADDR == ADDR_COUNT)  ? {16'h0000, count} :
    (S_AXI_ARADDR == ADDR_PERIOD) ? {16'h0000, period} :
    (S_AXI_ARADDR == ADDR_DIVX)   ? {29'h0, cfg.div2} :
    (S_AXI_ARADDR == ADDR_FLAGS)  ? {30'h0, cmp_flag, ovf_flag} :
                                    32'h0000_0000;

  // read data registered; counter read is a plain sample, no voting
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= 32'h0000_0000;
      S_AXI_RRESP  <= RESP_OKAY;
    end else if (ar_fire) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA  <= rd_word;
      S_AXI_RRESP  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  // ****************************************************************
  // clock select and dividers
  // ****************************************************************
  logic       clear_pulse;   // count_clear_bit written as one
  logic       src_edge;      // edge of the selected source
  logic [2:0] div1_reload;   // first ratio minus one
  logic       div1_tick;     // first divider output
  logic       tick;          // final timer clock event
  logic [2:0] next_div1;
  logic [2:0] next_div2;

  assign clear_pulse = wr_ctrl & w_strb[0] & w_data[CTRL_CLR_BIT];
  assign src_edge    = src_rise[cfg.src];
  assign div1_reload = 3'((4'h1 << cfg.div1) - 4'h1);
  // down counters at zero fire on the very next edge after a clear
  assign div1_tick   = src_edge && div1_cnt == DIV_RST;
  assign tick        = div1_tick && div2_cnt == DIV_RST;

  // reload on expiry, otherwise step down once per input event
  always_comb begin
    next_div1 = div1_cnt;
    next_div2 = div2_cnt;
    if (clear_pulse) begin
      next_div1 = DIV_RST;
      next_div2 = DIV_RST;
    end else begin
      if (src_edge) begin
        next_div1 = div1_tick ? div1_reload : div1_cnt - 3'h1;
      end
      if (div1_tick) begin
        next_div2 = (div2_cnt == DIV_RST) ? cfg.div2 : div2_cnt - 3'h1;
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      div1_cnt <= DIV_RST;
      div2_cnt <= DIV_RST;
    end else begin
      div1_cnt <= next_div1;
      div2_cnt <= next_div2;
    end
  end

  // ****************************************************************
  // counter and mode logic
  // ****************************************************************
  logic [15:0] inc;          // count plus one
  logic [15:0] dec;          // count minus one
  logic [15:0] next_count;
  logic        next_dir;
  logic        set_ovf;      // counted into overflow
  logic        set_cmp;      // counted onto the period value
  logic        sw_touch;     // software owns the counter this cycle
  logic        restart;      // period left zero in up or up/down

  assign inc      = count + COUNT_ONE;
  assign dec      = count - COUNT_ONE;
  assign sw_touch = clear_pulse | wr_count;
  assign restart  = wr_period && period == PERIOD_RST &&
                    wr_merge != PERIOD_RST &&
                    (cfg.mode == MODE_UP || cfg.mode == MODE_UPDOWN);

  always_comb begin
    next_count = count;
    next_dir   = dir_down;
    set_ovf    = 1'b0;
    set_cmp    = 1'b0;
    if (tick) begin
      unique case (cfg.mode)
        MODE_STOP: begin
          next_count = count;
        end
        MODE_UP: begin
          // zero period parks the counter
          if (period != PERIOD_RST) begin
            if (count >= period) begin
              next_count = COUNT_RST;
              set_ovf    = count == period;
            end else begin
              next_count = inc;
              set_cmp    = inc == period;
            end
          end
        end
        MODE_CONT: begin
          next_count = inc;
          set_ovf    = count == COUNT_MAX;
          set_cmp    = inc == period;
        end
        MODE_UPDOWN: begin
          if (period != PERIOD_RST) begin
            if (!dir_down && count < period) begin
              next_count = inc;
              set_cmp    = inc == period;
            end else if (!dir_down || count != COUNT_RST) begin
              // turn at the top, then descend to zero
              next_dir   = 1'b1;
              next_count = dec;
              if (count == COUNT_ONE) begin
                set_ovf  = 1'b1;
                next_dir = 1'b0;
              end
            end else begin
              next_dir   = 1'b0;
              next_count = inc;
            end
          end
        end
      endcase
    end
    // software action wins and counted events are dropped
    if (sw_touch) begin
      set_ovf = 1'b0;
      set_cmp = 1'b0;
    end
    if (clear_pulse || restart) begin
      next_count = COUNT_RST;
      next_dir   = 1'b0;
    end else if (wr_count) begin
      next_count = wr_merge;
    end
  end

  // counter, direction and period registers
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      count    <= COUNT_RST;
      dir_down <= 1'b0;
      period   <= PERIOD_RST;
    end else begin
      count    <= next_count;
      dir_down <= next_dir;
      if (wr_period) begin
        period <= wr_merge;
      end
    end
  end

  // config register; fields only change on their own lane
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      cfg <= CFG_RST;
    end else begin
      if (wr_ctrl && w_strb[0]) begin
        cfg.mode <= stc_mode_t'(w_data[CTRL_MODE_LSB +: 2]);
        cfg.div1 <= w_data[CTRL_DIV1_LSB +: 2];
      end
      if (wr_ctrl && w_strb[1]) begin
        cfg.src  <= w_data[CTRL_SRC_LSB +: 2];
      end
      if (wr_divx && w_strb[0]) begin
        cfg.div2 <= w_data[2:0];
      end
    end
  end

  // ****************************************************************
  // event flags, set beats a same-cycle write-one clear
  // ****************************************************************
  logic clr_ovf;
  logic clr_cmp;
  assign clr_ovf = wr_flags & w_strb[0] & w_data[FLAG_OVF_BIT];
  assign clr_cmp = wr_flags & w_strb[0] & w_data[FLAG_CMP_BIT];

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      ovf_flag <= 1'b0;
      cmp_flag <= 1'b0;
    end else begin
      ovf_flag <= set_ovf | (ovf_flag & ~clr_ovf);
      cmp_flag <= set_cmp | (cmp_flag & ~clr_cmp);
    end
  end

  // requests follow the sticky flags
  assign TIMER_OVF_IRQ = ovf_flag;
  assign TIMER_CMP_IRQ = cmp_flag;

  // ****************************************************************
  // assertions
  // ****************************************************************
  // no selected source edge seen since the last clear; lets the
  // first edge check reach that edge however late it comes
  logic fresh_clear;
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      fresh_clear <= 1'b0;
    end else if (clear_pulse) begin
      fresh_clear <= 1'b1;
    end else if (src_edge) begin
      fresh_clear <= 1'b0;
    end
  end

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SRST);

  clear_zeroes_a: assert property (
    clear_pulse |=> count == COUNT_RST && !dir_down &&
                    div1_cnt == DIV_RST && div2_cnt == DIV_RST)
    else $error("clear did not zero counter state");

  sw_load_a: assert property (
    wr_count && !clear_pulse && w_strb[1:0] == 2'h3
      |=> count == $past(w_data[15:0]))
    else $error("counter write not loaded at once");

  first_edge_a: assert property (
    fresh_clear && src_edge |-> tick)
    else $error("no timer tick on first edge after clear");

  stop_hold_a: assert property (
    cfg.mode == MODE_STOP && !sw_touch && !restart |=> $stable(count))
    else $error("counter moved while stopped");

  up_wrap_a: assert property (
    tick && cfg.mode == MODE_UP && count == period &&
    period != PERIOD_RST && !sw_touch
      |=> count == COUNT_RST && ovf_flag)
    else $error("up mode wrap or overflow flag missing");

  up_cmp_a: assert property (
    tick && cfg.mode == MODE_UP && count < period &&
    inc == period && !sw_touch |=> cmp_flag && count == period)
    else $error("compare flag missing at period");

  over_restart_a: assert property (
    tick && cfg.mode == MODE_UP && count > period &&
    period != PERIOD_RST && !sw_touch
      |=> count == COUNT_RST && $stable(ovf_flag))
    else $error("counter above period did not restart");

  cont_wrap_a: assert property (
    tick && cfg.mode == MODE_CONT && count == COUNT_MAX &&
    !sw_touch |=> count == COUNT_RST && ovf_flag)
    else $error("continuous mode did not wrap");

  updown_turn_a: assert property (
    tick && cfg.mode == MODE_UPDOWN && !dir_down &&
    count == period && period > COUNT_ONE && !sw_touch
      |=> dir_down && count == $past(dec))
    else $error("up/down mode did not turn at period");

  load_quiet_a: assert property (
    wr_count && !wr_flags |=> $stable(ovf_flag) && $stable(cmp_flag))
    else $error("software load raised a flag");

  zero_period_a: assert property (
    cfg.mode == MODE_UP && period == PERIOD_RST && !sw_touch &&
    !restart |=> $stable(count))
    else $error("zero period did not stop the counter");

  reset_state_a: assert property (
    @(posedge SYS_CLK) disable iff (1'b0)
    SRST |=> count == COUNT_RST && cfg.mode == MODE_STOP)
    else $error("reset left counter or mode set");

  up_wrap_c: cover property (
    tick && cfg.mode == MODE_UP && count == period ##1 ovf_flag);
  updown_bottom_c: cover property (
    tick && cfg.mode == MODE_UPDOWN && dir_down && count == COUNT_ONE);
  divided_tick_c: cover property (
    tick && cfg.div1 != 2'h0 && cfg.div2 != DIV_RST);

endmodule : stc_timer_core

/* stc_pkg.sv */
// ****************************************************************
// shared constants and types for the sixteen bit timer core
// ****************************************************************
package stc_pkg;

  // ****************************************************************
  // bus geometry
  // ****************************************************************
  localparam int ADDR_W = 8;                 // byte address width

  // register byte offsets
  localparam logic [7:0] ADDR_CTRL   = 8'h00; // control / config
  localparam logic [7:0] ADDR_COUNT  = 8'h04; // count_value_reg
  localparam logic [7:0] ADDR_PERIOD = 8'h08; // period_compare_reg
  localparam logic [7:0] ADDR_DIVX   = 8'h0C; // second divider
  localparam logic [7:0] ADDR_FLAGS  = 8'h10; // event flags, w1c

  // control register field positions
  localparam int CTRL_CLR_BIT  = 2;  // count_clear_bit, self clearing
  localparam int CTRL_MODE_LSB = 4;  // mode_control_field [5:4]
  localparam int CTRL_DIV1_LSB = 6;  // first_divider_field [7:6]
  localparam int CTRL_SRC_LSB  = 8;  // clock_source_select [9:8]
  // flag register field positions
  localparam int FLAG_OVF_BIT  = 0;  // overflow_flag
  localparam int FLAG_CMP_BIT  = 1;  // compare_flag

  // reset values
  localparam logic [15:0] COUNT_RST  = 16'h0000;
  localparam logic [15:0] PERIOD_RST = 16'h0000;
  localparam logic [15:0] COUNT_MAX  = 16'hFFFF; // full scale
  localparam logic [15:0] COUNT_ONE  = 16'h0001;
  localparam logic [2:0]  DIV_RST    = 3'h0;

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // operating modes, in encoding order 00..11
  typedef enum logic [1:0] {
    MODE_STOP,
    MODE_UP,
    MODE_CONT,
    MODE_UPDOWN
  } stc_mode_t;

  // configuration that travels together
  typedef struct packed {
    logic [1:0] src;   // clock source select
    logic [1:0] div1;  // first divider, 1/2/4/8
    stc_mode_t  mode;  // operating mode
    logic [2:0] div2;  // second divider, value + 1
  } stc_cfg_t;

  localparam stc_cfg_t CFG_RST = '{2'h0, 2'h0, MODE_STOP, 3'h0};

endpackage : stc_pkg

/* stc_timer_core_tb.sv */
`timescale 1ns/100ps
// ****************************************************************
// self checking bench for the timer core
// ****************************************************************
module stc_timer_core_tb;
  import stc_pkg::*;
  logic        SYS_CLK = 1'b0;  // 20 MHz system clock
  logic        SRST    = 1'b1;  // sync reset, high
  logic [3:0]  src     = '0;    // timer source pins, idle low
  logic [7:0]  awaddr  = '0;
  logic [7:0]  araddr  = '0;
  logic [31:0] wdata   = '0;
  logic [3:0]  wstrb   = 4'hF;  // byte lanes, narrowed for lane tests
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid, ovf_irq, cmp_irq;
  logic [1:0]  bresp, rresp, resp;
  logic [31:0] rdata, rd;
  int          fail_count = 0, n_tests = 0, seed = 32'hed0c;
  int          c, p;
  int          ud[4] = '{1, 2, 1, 0}; // up/down walk, period 2

  always #25 SYS_CLK = ~SYS_CLK;

  stc_timer_core u_dut (
    .SYS_CLK(SYS_CLK), .SRST(SRST), .AUX_CLOCK(src[0]),
    .SUB_MAIN_CLOCK(src[1]), .EXTERNAL_TIMER_CLOCK(src[2]),
    .ALTERNATE_EXTERNAL_CLOCK(src[3]),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .TIMER_OVF_IRQ(ovf_irq), .TIMER_CMP_IRQ(cmp_irq));

  // control word from its fields
  function automatic logic [31:0] cw(input int s, d1, m, clr);
    return 32'((s << CTRL_SRC_LSB) | (d1 << CTRL_DIV1_LSB) |
               (m << CTRL_MODE_LSB) | (clr << CTRL_CLR_BIT));
  endfunction : cw

  // next count in up mode after one tick
  function automatic logic [31:0] up_nx(input int cv, pv);
    return (cv < pv) ? 32'(cv + 1) : 32'h0000_0000;
  endfunction : up_nx

  task automatic chk(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask : chk

  // handshake seen at negedge, acted on at the next rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic ta, tw, tb;
    n = 0;
    tb = 0;
    @(posedge SYS_CLK);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!tb && n < 100) begin
      @(negedge SYS_CLK);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid;
      resp = bresp;
      @(posedge SYS_CLK);
      if (ta) awvalid <= 0;
      if (tw) wvalid <= 0;
      n++;
    end
    bready <= 0;
    chk("bvalid", 1, tb);
  endtask : wr

  task automatic rdk(input logic [7:0] a, input logic [31:0] e,
                     input string nm);
    int n;
    logic ta, tr;
    n = 0;
    tr = 0;
    @(posedge SYS_CLK);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    while (!tr && n < 100) begin
      @(negedge SYS_CLK);
      ta = arvalid & arready;
      tr = rvalid;
      rd = rdata;
      resp = rresp;
      @(posedge SYS_CLK);
      if (ta) arvalid <= 0;
      n++;
    end
    rready <= 0;
    chk("rvalid", 1, tr);
    chk(nm, e, rd);
  endtask : rdk

  // k clean source pulses; each outlasts the pin synchroniser
  task automatic pulse(input int s, input int k);
    repeat (k) begin
      @(posedge SYS_CLK);
      src[s] <= 1'b1;
      repeat (3) @(posedge SYS_CLK);
      src[s] <= 1'b0;
      repeat (5) @(posedge SYS_CLK);
    end
  endtask : pulse

  task automatic end_sim;
    if (fail_count == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_sim

  // watchdog, far beyond the several hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge SYS_CLK);
    fail_count++;
    end_sim();
  end

  initial begin
    repeat (6) @(posedge SYS_CLK);
    SRST <= 1'b0;
    rdk(ADDR_COUNT, 0, "count_rst");
    rdk(ADDR_CTRL, 0, "ctrl_rst");
    rdk(8'h14, 0, "unmapped");
    chk("unmapped_resp", RESP_SLVERR, resp);
    wr(8'h14, 1);
    chk("wr_unmapped", RESP_SLVERR, resp);
    wr(ADDR_PERIOD, 3);
    chk("wr_okay", RESP_OKAY, resp);
    wr(ADDR_CTRL, cw(1, 0, 1, 1));
    pulse(1, 3);
    rdk(ADDR_COUNT, 3, "up_top");
    chk("cmp_irq", 1, cmp_irq);
    chk("ovf_early", 0, ovf_irq);
    pulse(1, 1);
    rdk(ADDR_COUNT, 0, "up_wrap");
    chk("ovf_irq", 1, ovf_irq);
    wr(ADDR_FLAGS, 3);
    wr(ADDR_COUNT, 3);
    rdk(ADDR_COUNT, 3, "load");
    chk("cmp_load", 0, cmp_irq);
    wstrb <= 4'h1;
    wr(ADDR_COUNT, 32'h0000_AB12);
    wstrb <= 4'hF;
    rdk(ADDR_COUNT, 32'h0000_0012, "lane_load");
    wr(ADDR_COUNT, 9);
    pulse(1, 1);
    rdk(ADDR_COUNT, 0, "above_per");
    chk("ovf_above", 0, ovf_irq);
    wr(ADDR_CTRL, cw(1, 0, 0, 0));
    pulse(1, 2);
    rdk(ADDR_COUNT, 0, "stop_hold");
    wr(ADDR_CTRL, cw(1, 0, 1, 0));
    pulse(1, 2);
    wr(ADDR_PERIOD, 0);
    pulse(1, 2);
    rdk(ADDR_COUNT, 2, "per0_hold");
    wr(ADDR_PERIOD, 5);
    rdk(ADDR_COUNT, 0, "restart");
    wr(ADDR_FLAGS, 3);
    wr(ADDR_COUNT, 32'h0000_FFFE);
    wr(ADDR_CTRL, cw(1, 0, 2, 0));
    pulse(1, 2);
    rdk(ADDR_COUNT, 0, "cont_wrap");
    chk("ovf_cont", 1, ovf_irq);
    wr(ADDR_FLAGS, 3);
    wr(ADDR_PERIOD, 2);
    wr(ADDR_CTRL, cw(1, 0, 3, 1));
    foreach (ud[i]) begin
      pulse(1, 1);
      rdk(ADDR_COUNT, ud[i], "updown");
    end
    chk("ovf_ud", 1, ovf_irq);
    // ratio 2 x 3 = 6 after clear
    wr(ADDR_CTRL, cw(1, 0, 0, 0));
    wr(ADDR_DIVX, 2);
    wr(ADDR_CTRL, cw(1, 1, 2, 1));
    pulse(1, 1);
    rdk(ADDR_COUNT, 1, "div_first");
    pulse(1, 5);
    rdk(ADDR_COUNT, 1, "div_hold");
    pulse(1, 1);
    rdk(ADDR_COUNT, 2, "div_next");
    wr(ADDR_CTRL, cw(1, 1, 2, 1));
    rdk(ADDR_COUNT, 0, "clr_count");
    rdk(ADDR_CTRL, cw(1, 1, 2, 0), "clr_keep");
    rdk(ADDR_DIVX, 2, "clr_divx");
    wr(ADDR_DIVX, 0);
    for (int s = 0; s < 4; s++) begin
      wr(ADDR_CTRL, cw(s, 0, 2, 1));
      pulse((s + 1) % 4, 1);
      pulse(s, 1);
      rdk(ADDR_COUNT, 1, "src_sel");
    end
    repeat (8) begin
      p = ($random(seed) & 15) + 1;
      c = $random(seed) & 31;
      wr(ADDR_CTRL, cw(1, 0, 0, 0));
      wr(ADDR_PERIOD, 32'(p));
      wr(ADDR_COUNT, 32'(c));
      wr(ADDR_CTRL, cw(1, 0, 1, 0));
      pulse(1, 1);
      rdk(ADDR_COUNT, up_nx(c, p), "rand_up");
    end
    end_sim();
  end
endmodule : stc_timer_core_tb
